// ### omb_pkg.sv
// package for the operating-mode and bus-configuration block
// assumes a single clock domain and no register bus
package omb_pkg;
   // decoded operating modes, codes equal mode number
   typedef enum logic [2:0] {
      OMB_MODE4 = 3'h4,
      OMB_MODE5 = 3'h5,
      OMB_MODE6 = 3'h6,
      OMB_MODE7 = 3'h7
   } omb_mode_e;

   // bus width encodings
   localparam logic OMB_BUS_8  = 1'b0;
   localparam logic OMB_BUS_16 = 1'b1;

   // number of areas and per-area width bit meaning (1 = 8-bit)
   localparam int   OMB_AREAS       = 8;
   localparam logic [7:0] OMB_ABW_ALL8  = 8'hFF;
   localparam logic [7:0] OMB_ABW_ALL16 = 8'h00;

   // address space: 24 address bits = 16 Mbytes
   localparam int   OMB_ADDR_W = 24;

   // reset values
   localparam logic [2:0] OMB_PINS_RST = 3'h7;
   localparam logic       OMB_ONCHIP_RAM_ENABLE_BIT_RST = 1'b1;
   // enabled edges after release before both strap stages hold pin levels
   localparam logic [1:0] OMB_SYNC_FILL = 2'h2;
endpackage : omb_pkg

// ### omb_mode_ctrl.sv
// operating-mode decode and external bus configuration
// assumes mode straps are held stable by the board through reset
// Functional notes
// RULE1: the three mode pins 100..111 select modes 4 to 7.
// RULE2: modes 4 and 5 disable ROM; port 1 low bits and ports A-C carry address, D-E data, part of F control.
// RULE3: mode 4 starts 16-bit and drops to 8-bit only when all areas are 8-bit.
// RULE4: modes 5 and 6 start 8-bit and go 16-bit with port E as data once any area is 16-bit; mode 5 here drives port E as data at either width.
// RULE5: mode 6 enables ROM and still allows external space.
// RULE6: mode 6 keeps address ports as inputs until pin state control or port C direction bits enable them.
// RULE7: mode 7 enables ROM, blocks external access and frees all ports for general I/O.
// RULE8: every mode gives a 16-Mbyte linear advanced-mode space.
// RULE9: clearing the on-chip RAM enable bit routes the RAM region to external space; here only in modes 4 to 6, as mode 7 has no external space.
// RULE10: the mode is latched at reset release and held until the next reset.
`timescale 1ns/10ps
module omb_mode_ctrl
   import omb_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        clk_en,
   input  wire logic        mode_select_pin_2,
   input  wire logic        mode_select_pin_1,
   input  wire logic        mode_select_pin_0,
   input  wire logic [7:0]  area_width_8bit,
   input  wire logic        onchip_ram_enable_bit,
   input  wire logic        pin_state_p1_addr_en,
   input  wire logic        pin_state_pa_addr_en,
   input  wire logic        pin_state_pb_addr_en,
   input  wire logic [7:0]  port_c_dir,
   input  wire logic        ram_region_hit,
   output logic [2:0]       op_mode,
   output logic             mode_valid,
   output logic             advanced_mode,
   output logic [4:0]       addr_space_log2_mb,
   output logic             onchip_rom_en,
   output logic             ext_space_en,
   output logic             bus_width_16,
   output logic             port_e_data_en,
   output logic             port_d_data_en,
   output logic             port_f_ctrl_en,
   output logic             port_1_addr_en,
   output logic             port_a_addr_en,
   output logic             port_b_addr_en,
   output logic [7:0]       port_c_addr_en,
   output logic             ram_access_external
);

   // pin synchronisers, first stage read only by second
   logic [2:0]  pins_s1_ff,  nxt_pins_s1;
   logic [2:0]  pins_s2_ff,  nxt_pins_s2;
   // latch capture state and latched mode
   logic        latched_ff,  nxt_latched;
   logic [1:0]  fill_ff,     nxt_fill;
   omb_mode_e   mode_ff,     nxt_mode;
   // registered outputs
   logic        rom_ff, ext_ff, w16_ff, pe_ff, pd_ff, pf_ff;
   logic        nxt_rom, nxt_ext, nxt_w16, nxt_pe, nxt_pd, nxt_pf;
   logic        p1_ff, pa_ff, pb_ff, rx_ff;
   logic        nxt_p1, nxt_pa, nxt_pb, nxt_rx;
   logic [7:0]  pc_ff, nxt_pc;

   // decode a pin pattern into a mode
   function automatic omb_mode_e omb_decode(input logic [2:0] p);
      case (p)
         3'h4:    omb_decode = OMB_MODE4; // RULE1
         3'h5:    omb_decode = OMB_MODE5; // RULE1
         3'h6:    omb_decode = OMB_MODE6; // RULE1
         3'h7:    omb_decode = OMB_MODE7; // RULE1
         default: omb_decode = OMB_MODE7; // unsupported straps fall back
      endcase
   endfunction : omb_decode

   // bus width from the per-area bits: 8-bit only when every area is 8-bit,
   // which covers the mode 4 drop and the mode 5/6 rise alike
   function automatic logic omb_width(input logic [7:0] abw);
      omb_width = (abw == OMB_ABW_ALL8) ? OMB_BUS_8 : OMB_BUS_16;
   endfunction : omb_width

   // mode capture: the second strap stage still holds its reset pattern
   // until the second enabled edge after release, so the straps are read only
   // once the fill count says both stages carry real pin levels
   always_comb begin
      nxt_pins_s1 = {mode_select_pin_2, mode_select_pin_1,
                     mode_select_pin_0};
      nxt_pins_s2 = pins_s1_ff;
      nxt_fill    = fill_ff;
      nxt_latched = latched_ff;
      nxt_mode    = mode_ff;                                  // RULE10
      if (fill_ff != OMB_SYNC_FILL) begin
         nxt_fill = fill_ff + 2'h1;
      end else if (!latched_ff) begin
         nxt_latched = 1'b1;                                  // RULE10
         nxt_mode    = omb_decode(pins_s2_ff);                // RULE10
      end
   end

   // bus and port configuration from the held mode
   always_comb begin
      // defaults: ROM on, ports D and F owned, port E and address pins released
      nxt_rom = 1'b1;
      nxt_ext = 1'b1;
      nxt_w16 = OMB_BUS_8;
      nxt_pe  = 1'b0;
      nxt_pd  = 1'b1;
      nxt_pf  = 1'b1;
      nxt_p1  = 1'b0;
      nxt_pa  = 1'b0;
      nxt_pb  = 1'b0;
      nxt_pc  = 8'h00;
      case (mode_ff)
         OMB_MODE4: begin
            // expanded, ROM off, 16-bit unless every area is 8-bit
            nxt_rom = 1'b0;                                   // RULE2
            nxt_p1  = 1'b1;                                   // RULE2
            nxt_pa  = 1'b1;                                   // RULE2
            nxt_pb  = 1'b1;                                   // RULE2
            nxt_pc  = 8'hFF;                                  // RULE2
            nxt_w16 = omb_width(area_width_8bit);             // RULE3
            nxt_pe  = 1'b1;                                   // RULE2
         end
         OMB_MODE5: begin
            nxt_rom = 1'b0;                                   // RULE2
            nxt_p1  = 1'b1;                                   // RULE2
            nxt_pa  = 1'b1;                                   // RULE2
            nxt_pb  = 1'b1;                                   // RULE2
            nxt_pc  = 8'hFF;                                  // RULE2
            nxt_w16 = omb_width(area_width_8bit);             // RULE4
            nxt_pe  = 1'b1;                                   // RULE2
         end
         OMB_MODE6: begin
            // address lines stay inputs until software hands them over
            nxt_rom = 1'b1;                                   // RULE5
            nxt_ext = 1'b1;                                   // RULE5
            nxt_p1  = pin_state_p1_addr_en;                   // RULE6
            nxt_pa  = pin_state_pa_addr_en;                   // RULE6
            nxt_pb  = pin_state_pb_addr_en;                   // RULE6
            nxt_pc  = port_c_dir;                             // RULE6
            nxt_w16 = omb_width(area_width_8bit);             // RULE4
            nxt_pe  = nxt_w16;                                // RULE4
         end
         OMB_MODE7: begin
            // single-chip: no external space, every port general I/O
            nxt_rom = 1'b1;                                   // RULE7
            nxt_ext = 1'b0;                                   // RULE7
            nxt_pd  = 1'b0;                                   // RULE7
            nxt_pf  = 1'b0;                                   // RULE7
         end
         default: begin
            nxt_ext = 1'b0;
            nxt_pd  = 1'b0;
            nxt_pf  = 1'b0;
         end
      endcase
      // ram region goes external only when external space exists
      nxt_rx = ram_region_hit & ~onchip_ram_enable_bit & nxt_ext; // RULE9
   end

   // capture registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pins_s1_ff <= OMB_PINS_RST;
         pins_s2_ff <= OMB_PINS_RST;
         latched_ff <= 1'b0;
         fill_ff    <= 2'h0;
         mode_ff    <= OMB_MODE7;
      end else if (clk_en) begin
         pins_s1_ff <= nxt_pins_s1;
         pins_s2_ff <= nxt_pins_s2;
         latched_ff <= nxt_latched;
         fill_ff    <= nxt_fill;
         mode_ff    <= nxt_mode;
      end
   end

   // configuration registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rom_ff <= 1'b1;
         ext_ff <= 1'b0;
         w16_ff <= OMB_BUS_8;
         pe_ff  <= 1'b0;
         pd_ff  <= 1'b0;
         pf_ff  <= 1'b0;
         p1_ff  <= 1'b0;
         pa_ff  <= 1'b0;
         pb_ff  <= 1'b0;
         pc_ff  <= 8'h00;
         rx_ff  <= 1'b0;
      end else if (clk_en) begin
         rom_ff <= nxt_rom;
         ext_ff <= nxt_ext;
         w16_ff <= nxt_w16;
         pe_ff  <= nxt_pe;
         pd_ff  <= nxt_pd;
         pf_ff  <= nxt_pf;
         p1_ff  <= nxt_p1;
         pa_ff  <= nxt_pa;
         pb_ff  <= nxt_pb;
         pc_ff  <= nxt_pc;
         rx_ff  <= nxt_rx;
      end
   end

   // outputs: configuration only valid after the mode is held
   assign op_mode             = mode_ff;
   assign mode_valid          = latched_ff;
   // every mode is the same 24-bit advanced space, so these are fixed
   assign advanced_mode       = 1'b1;                         // RULE8
   assign addr_space_log2_mb  = 5'h04;                        // RULE8
   assign onchip_rom_en       = rom_ff;
   assign ext_space_en        = ext_ff;
   assign bus_width_16        = w16_ff;
   assign port_e_data_en      = pe_ff;
   assign port_d_data_en      = pd_ff;
   assign port_f_ctrl_en      = pf_ff;
   assign port_1_addr_en      = p1_ff;
   assign port_a_addr_en      = pa_ff;
   assign port_b_addr_en      = pb_ff;
   assign port_c_addr_en      = pc_ff;
   assign ram_access_external = rx_ff;

endmodule : omb_mode_ctrl

// ### omb_mode_ctrl_sva.sv
// checker on the mode block ports
// assumes a bind to omb_mode_ctrl, single clock
`timescale 1ns/10ps
module omb_mode_ctrl_sva
   import omb_pkg::*;
(
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       clk_en,
   input wire logic [7:0] area_width_8bit,
   input wire logic       onchip_ram_enable_bit,
   input wire logic       ram_region_hit,
   input wire logic [7:0] port_c_dir,
   input wire logic [2:0] op_mode,
   input wire logic       mode_valid,
   input wire logic       onchip_rom_en,
   input wire logic       ext_space_en,
   input wire logic       bus_width_16,
   input wire logic [7:0] port_c_addr_en,
   input wire logic       port_e_data_en,
   input wire logic       port_d_data_en,
   input wire logic       port_f_ctrl_en,
   input wire logic       port_1_addr_en,
   input wire logic       ram_access_external
);
   // outputs against the held mode and last inputs
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   AST_MODE: assert property (mode_valid |-> op_mode[2])
      else $error("mode out of range");
   AST_ROM: assert property ($past(mode_valid) |->
      onchip_rom_en == op_mode[1]) else $error("rom enable wrong");
   AST_EXT: assert property ($past(mode_valid) |->
      ext_space_en == !(&op_mode)) else $error("ext enable wrong");
   AST_WIDTH: assert property ($past(mode_valid)
      && $past(clk_en) && !(&op_mode)
      |-> bus_width_16 == ($past(area_width_8bit) != OMB_ABW_ALL8))
      else $error("bus width wrong");
   AST_PORTC: assert property ($past(mode_valid) && $past(clk_en)
      && op_mode == 3'h6 |-> port_c_addr_en == $past(port_c_dir))
      else $error("port C wrong");
   AST_M7: assert property ($past(mode_valid) && (&op_mode)
      |-> port_c_addr_en == 8'h00) else $error("port C not free");
   AST_RAM: assert property ($past(mode_valid) && $past(clk_en)
      && !(&op_mode) |-> ram_access_external == ($past(ram_region_hit) &&
      !$past(onchip_ram_enable_bit))) else $error("ram routing wrong");
   AST_PORTE: assert property ($past(mode_valid) |->
      port_e_data_en == (!op_mode[1] || (op_mode == 3'h6 && bus_width_16)))
      else $error("port E wrong");
   AST_EXPAND: assert property ($past(mode_valid) && !op_mode[1] |->
      port_1_addr_en && port_d_data_en && port_f_ctrl_en &&
      port_c_addr_en == 8'hFF) else $error("expanded ports wrong");
   AST_SINGLE: assert property ($past(mode_valid) && (&op_mode) |->
      !port_1_addr_en && !port_d_data_en && !port_f_ctrl_en &&
      !port_e_data_en) else $error("single-chip ports not free");
   AST_HOLD: assert property (mode_valid && $past(mode_valid)
      |-> $stable(op_mode)) else $error("mode changed");
endmodule : omb_mode_ctrl_sva

// ### omb_strap_model.sv
// board strap model for the three mode pins
// assumes the bench sets the code while reset is held
`timescale 1ns/10ps
module omb_strap_model (
   input  wire logic [2:0] mode_code,
   output logic            mode_select_pin_2,
   output logic            mode_select_pin_1,
   output logic            mode_select_pin_0
);
   // plain jumper levels, steady through reset
   assign {mode_select_pin_2, mode_select_pin_1} = mode_code[2:1];
   assign mode_select_pin_0 = mode_code[0];
endmodule : omb_strap_model

// ### omb_mode_ctrl_tb.sv
// bench for the mode block with the strap model
// assumes the checker bound at the foot
`timescale 1ns/10ps
module omb_mode_ctrl_tb import omb_pkg::*; ;
   logic       mclk = 1'b0, rst = 1'b1, clk_en = 1'b1;
   logic       onchip_ram_enable_bit = 1'b1, ram_region_hit = 1'b0;
   logic [7:0] area_width_8bit = 8'hFF, port_c_dir = 8'h00, port_c_addr_en;
   logic [2:0] mode_code = 3'h7, op_mode;
   logic [4:0] addr_space_log2_mb;
   logic       mode_select_pin_2, mode_select_pin_1, mode_select_pin_0;
   logic       mode_valid, advanced_mode, onchip_rom_en, ext_space_en;
   logic       bus_width_16, port_e_data_en, port_d_data_en, port_f_ctrl_en;
   logic       port_1_addr_en, port_a_addr_en, port_b_addr_en;
   logic       ram_access_external;
   logic       pin_state_p1_addr_en = 1'b0, pin_state_pa_addr_en = 1'b0;
   logic       pin_state_pb_addr_en = 1'b0;
   int         error_cnt = 0, cmp_count = 0;
   // straps, block and clock
   omb_strap_model brd (.*);
   omb_mode_ctrl uut (.*);
   initial forever #2 mclk = ~mclk;
   // compare and count
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) error_cnt++;
      if (g !== e) $display("Error %s expected %h seen %h", n, e, g);
   endtask : chk
   task automatic results;
      $display("checks %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : results
   // boot in mode m, then width change and ram routing
   task automatic t_mode(logic [2:0] m);
      @(negedge mclk);
      rst = 1'b1;
      mode_code = m;
      area_width_8bit = (m == 3'h4) ? 8'h00 : OMB_ABW_ALL8;
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      for (int i = 0; i < 20 && mode_valid !== 1'b1; i++) @(negedge mclk);
      chk("valid", 8'h01, mode_valid);
      if (mode_valid !== 1'b1) results();
      repeat (4) @(negedge mclk);
      chk("op_mode", m, op_mode);
      chk("rom", m[1], onchip_rom_en);
      if (m != 3'h7) chk("width0", m == 3'h4, bus_width_16);
      chk("ext", m != 3'h7, ext_space_en);
      chk("p1", m < 3'h6, port_1_addr_en);
      chk("pa", m < 3'h6, port_a_addr_en);
      chk("pb", m < 3'h6, port_b_addr_en);
      chk("pc", (m < 3'h6) ? 8'hFF : 8'h00, port_c_addr_en);
      chk("pd", m != 3'h7, port_d_data_en);
      chk("pf", m != 3'h7, port_f_ctrl_en);
      chk("pe0", m < 3'h6, port_e_data_en);
      chk("adv", 8'h01, advanced_mode);
      chk("space", 8'h04, addr_space_log2_mb);
      area_width_8bit = (m == 3'h4) ? OMB_ABW_ALL8 : 8'h7F;
      onchip_ram_enable_bit = 1'b0;
      ram_region_hit = 1'b1;
      repeat (2) @(negedge mclk);
      if (m != 3'h7) chk("width", m != 3'h4, bus_width_16);
      chk("ram_ext", m != 3'h7, ram_access_external);
      chk("pe", m != 3'h7, port_e_data_en);
      onchip_ram_enable_bit = 1'b1;
   endtask : t_mode
   // mode 6 port C release and mode hold
   task automatic t_m6;
      t_mode(3'h6);
      chk("pc_in", 8'h00, port_c_addr_en);
      port_c_dir = 8'h0F;
      mode_code = 3'h4;
      repeat (3) @(negedge mclk);
      chk("pc_out", 8'h0F, port_c_addr_en);
      chk("hold", 8'h06, op_mode);
      pin_state_p1_addr_en = 1'b1;
      pin_state_pa_addr_en = 1'b1;
      repeat (2) @(negedge mclk);
      chk("p1_out", 8'h01, port_1_addr_en);
      chk("pa_out", 8'h01, port_a_addr_en);
      chk("pb_in", 8'h00, port_b_addr_en);
      clk_en = 1'b0;
      port_c_dir = 8'hF0;
      repeat (2) @(negedge mclk);
      chk("frozen", 8'h0F, port_c_addr_en);
      clk_en = 1'b1;
      repeat (2) @(negedge mclk);
      chk("pc_out2", 8'hF0, port_c_addr_en);
   endtask : t_m6
   initial begin
      for (int m = 4; m < 8; m++) t_mode(m[2:0]);
      t_m6();
      results();
   end
endmodule : omb_mode_ctrl_tb
bind omb_mode_ctrl omb_mode_ctrl_sva sva_i (.*);
